// *** design/sep_defs.svh ***
// Constants of the serial memory command port: frame layout, codes, sizes and timing.
`ifndef SEP_DEFS_SVH
`define SEP_DEFS_SVH

// =============================================================================
// Frame layout
// =============================================================================
`define SEP_OPC_LAST       4'h1
`define SEP_ALAST_X16      4'h5
`define SEP_ALAST_X8       4'h6
`define SEP_DLAST_X16      4'hf
`define SEP_DLAST_X8       4'h7
`define SEP_MSB_X16        4'hf
`define SEP_MSB_X8         4'h7

// =============================================================================
// Opcodes and sub-commands of opcode zero
// =============================================================================
`define SEP_OPC_READ       2'h2
`define SEP_OPC_ERASE      2'h3
`define SEP_OPC_WRITE      2'h1
`define SEP_SUB_ENABLE     2'h3
`define SEP_SUB_DISABLE    2'h0
`define SEP_SUB_CLEAR_ALL  2'h2
`define SEP_SUB_FILL_ALL   2'h1

// =============================================================================
// Array and reset values
// =============================================================================
`define SEP_DEPTH          64
`define SEP_ERASED         16'hffff
`define SEP_LAST_ADDR_X16  6'h3f

// =============================================================================
// Timing
// =============================================================================
`define SEP_CLK_PERIOD_NS  50
`define SEP_PROG_TIME_NS   5000000
`define SEP_PROG_CYCLES    (`SEP_PROG_TIME_NS / `SEP_CLK_PERIOD_NS)

`endif

// *** design/sep_pkg.sv ***
// Types shared by the serial memory command port modules.
package sep_pkg;

	// =========================================================================
	// Link frame states and decoded instructions
	// =========================================================================
	typedef enum logic [2:0] {
		SEP_IDLE,
		SEP_OPCODE,
		SEP_ADDRESS,
		SEP_DATA,
		SEP_READOUT,
		SEP_DONE
	} sep_state_type;

	typedef enum logic [2:0] {
		SEP_CMD_READ,
		SEP_CMD_WRITE,
		SEP_CMD_ERASE,
		SEP_CMD_PROGRAM_ENABLE,
		SEP_CMD_PROGRAM_DISABLE,
		SEP_CMD_CLEAR_ALL,
		SEP_CMD_FILL_ALL
	} sep_cmd_type;

	// A completed instruction handed from the link domain to the core.
	typedef struct packed {
		sep_cmd_type cmd;
		logic [6:0]  addr;
		logic [15:0] data;
	} sep_req_type;

endpackage

// *** design/sep_sync.sv ***
// Two-flip-flop level synchroniser.
`timescale 1ns/100ps

module sep_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_in,   // Destination clock.
	input  wire logic             nrst_in,  // Asynchronous reset, active low.
	input  wire logic [WIDTH-1:0] d_in,     // Level from another domain.
	output logic      [WIDTH-1:0] q_out     // Synchronised level.
);

	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			meta_reg <= '0;
			q_out    <= '0;
		end else begin
			meta_reg <= d_in;
			q_out    <= meta_reg;
		end
	end

endmodule

// *** design/sep_array.sv ***
// Memory array with the self-timed program engine.
`timescale 1ns/100ps
`include "sep_defs.svh"

module sep_array #(
	parameter int unsigned PROG_CYCLES = `SEP_PROG_CYCLES
) (
	input  wire logic                clk_in,      // Core clock.
	input  wire logic                nrst_in,     // Asynchronous reset, active low.
	input  wire logic                start_in,    // Pulse: begin a program cycle.
	input  wire sep_pkg::sep_req_type job_in,     // Instruction to carry out.
	input  wire logic                wide_in,     // High for 16-bit words.
	input  wire logic [6:0]          rd_addr_in,  // Read address.
	output logic      [15:0]         rd_data_out, // Read word, low-aligned.
	output logic                     busy_out     // High during a program cycle.
);

	logic [15:0]          mem [`SEP_DEPTH];
	logic [19:0]          timer_reg;
	sep_pkg::sep_req_type job_reg;
	logic                 done;
	logic [15:0]          value;
	logic                 all;

	// Merges a value into a word, by whole word or by byte lane.
	function automatic logic [15:0] put(input logic [15:0] m, input logic [15:0] v,
			input logic wide, input logic lane, input logic both);
		if (wide) begin
			put = v;
		end else if (both) begin
			put = {v[7:0], v[7:0]};
		end else if (lane) begin
			put = {v[7:0], m[7:0]};
		end else begin
			put = {m[15:8], v[7:0]};
		end
	endfunction

	function automatic logic [5:0] word_index(input logic [6:0] a, input logic wide);
		word_index = wide ? a[5:0] : a[6:1];
	endfunction

	assign done = busy_out && (timer_reg == 20'(PROG_CYCLES - 1));
	assign all  = (job_reg.cmd == sep_pkg::SEP_CMD_CLEAR_ALL) ||
	              (job_reg.cmd == sep_pkg::SEP_CMD_FILL_ALL);
	assign value = ((job_reg.cmd == sep_pkg::SEP_CMD_WRITE) ||
	               (job_reg.cmd == sep_pkg::SEP_CMD_FILL_ALL)) ? job_reg.data : `SEP_ERASED;

	// =========================================================================
	// Program timer, runs without any link clock
	// =========================================================================
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			busy_out  <= 1'b0;
			timer_reg <= 20'h00000;
			job_reg   <= '0;
		end else if (start_in) begin
			busy_out  <= 1'b1;
			timer_reg <= 20'h00000;
			job_reg   <= job_in;
		end else if (done) begin
			busy_out  <= 1'b0;
		end else if (busy_out) begin
			timer_reg <= timer_reg + 20'h00001;
		end
	end

	// =========================================================================
	// Array: auto-clear at start of a write, store at end of the cycle
	// =========================================================================
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			for (int i = 0; i < `SEP_DEPTH; i++) begin
				mem[i] <= `SEP_ERASED;
			end
		end else if (start_in && (job_in.cmd == sep_pkg::SEP_CMD_WRITE)) begin
			mem[word_index(job_in.addr, wide_in)] <= put(mem[word_index(job_in.addr, wide_in)],
				`SEP_ERASED, wide_in, job_in.addr[0], 1'b0);
		end else if (done) begin
			for (int i = 0; i < `SEP_DEPTH; i++) begin
				if (all || (6'(i) == word_index(job_reg.addr, wide_in))) begin
					mem[i] <= put(mem[i], value, wide_in, job_reg.addr[0], all);
				end
			end
		end
	end

	assign rd_data_out = wide_in ? mem[rd_addr_in[5:0]] :
	                     {8'h00, rd_addr_in[0] ? mem[rd_addr_in[6:1]][15:8] :
	                      mem[rd_addr_in[6:1]][7:0]};

endmodule

// *** design/sep_port.sv ***
// Serial command port of a small self-timed electrically erasable memory.
`timescale 1ns/100ps
`include "sep_defs.svh"

module sep_port #(
	parameter int unsigned PROG_CYCLES = `SEP_PROG_CYCLES
) (
	input  wire logic clk_in,             // Core clock, 20 MHz.
	input  wire logic nrst_in,            // Asynchronous reset, active low.
	input  wire logic serial_clock_in,    // Link clock from the host.
	input  wire logic device_select_in,   // Device select, active high.
	input  wire logic serial_in_in,       // Serial data from the host.
	input  wire logic width_select_in,    // High for 16-bit words.
	output logic      serial_out_out,     // Serial data to the host.
	output logic      serial_out_oe_out   // High while serial_out is driven.
);

	// =========================================================================
	// Declarations
	// =========================================================================
	sep_pkg::sep_state_type state_reg;
	logic [3:0]             cnt_reg;
	logic [1:0]             opc_reg;
	logic [6:0]             addr_reg;
	logic [15:0]            data_reg;
	logic [15:0]            shift_reg;
	logic [6:0]             rd_addr_reg;
	logic                   rd_active_reg;
	logic                   rd_bit_reg;
	logic                   start_seen_reg;
	sep_pkg::sep_req_type   req_reg;
	logic                   req_tgl_reg;
	logic                   start_tgl_reg;
	logic                   link_rst_n;

	logic [6:0]             addr_next;
	logic [15:0]            data_next;
	logic [1:0]             sub_next;
	sep_pkg::sep_cmd_type   cmd_next;
	logic                   addr_last;
	logic                   data_last;
	logic                   word_last;
	logic [3:0]             msb_idx;
	logic [6:0]             addr_inc;
	logic [6:0]             rd_addr;
	logic [15:0]            rd_word;

	logic                   cs_s;
	logic                   narrow_s;
	logic                   wide_s;
	logic                   req_s;
	logic                   start_s;
	logic                   cs_prev_reg;
	logic                   req_prev_reg;
	logic                   start_prev_reg;
	logic                   pending_reg;
	logic                   enable_reg;
	logic                   status_show_reg;
	logic                   busy_hit_reg;
	logic                   busy;
	logic                   cs_fall;
	logic                   req_edge;
	logic                   start_edge;
	logic                   exec;
	logic                   prog_start;
	logic                   prog_cmd;

	// Maps an opcode and the top two address bits to an instruction.
	function automatic sep_pkg::sep_cmd_type decode_cmd(input logic [1:0] opc,
			input logic [1:0] sub);
		decode_cmd = sep_pkg::SEP_CMD_READ;
		case (opc)
			`SEP_OPC_READ: begin
				decode_cmd = sep_pkg::SEP_CMD_READ;
			end
			`SEP_OPC_ERASE: begin
				decode_cmd = sep_pkg::SEP_CMD_ERASE;
			end
			`SEP_OPC_WRITE: begin
				decode_cmd = sep_pkg::SEP_CMD_WRITE;
			end
			default: begin
				case (sub)
					`SEP_SUB_ENABLE: begin
						decode_cmd = sep_pkg::SEP_CMD_PROGRAM_ENABLE;
					end
					`SEP_SUB_DISABLE: begin
						decode_cmd = sep_pkg::SEP_CMD_PROGRAM_DISABLE;
					end
					`SEP_SUB_CLEAR_ALL: begin
						decode_cmd = sep_pkg::SEP_CMD_CLEAR_ALL;
					end
					default: begin
						decode_cmd = sep_pkg::SEP_CMD_FILL_ALL;
					end
				endcase
			end
		endcase
	endfunction

	// =========================================================================
	// Link-side decode
	// =========================================================================
	// Deselect clears the frame logic, so a partial instruction is dropped.
	assign link_rst_n = nrst_in & device_select_in;

	always_comb begin
		addr_next = {addr_reg[5:0], serial_in_in};
		data_next = {data_reg[14:0], serial_in_in};
		sub_next  = wide_s ? addr_next[5:4] : addr_next[6:5];
		cmd_next  = decode_cmd(opc_reg, sub_next);
		addr_last = (cnt_reg == (wide_s ? `SEP_ALAST_X16 : `SEP_ALAST_X8));
		data_last = (cnt_reg == (wide_s ? `SEP_DLAST_X16 : `SEP_DLAST_X8));
		word_last = data_last;
		msb_idx   = wide_s ? `SEP_MSB_X16 : `SEP_MSB_X8;
		addr_inc  = wide_s ? {1'b0, rd_addr_reg[5:0] + 6'h01} : rd_addr_reg + 7'h01;
		rd_addr   = (state_reg == sep_pkg::SEP_ADDRESS) ?
		            (wide_s ? {1'b0, addr_next[5:0]} : addr_next) : addr_inc;
	end

	// =========================================================================
	// Link frame state machine, on the rising serial clock
	// =========================================================================
	always_ff @(posedge serial_clock_in or negedge link_rst_n) begin
		if (!link_rst_n) begin
			state_reg      <= sep_pkg::SEP_IDLE;
			cnt_reg        <= 4'h0;
			opc_reg        <= 2'h0;
			addr_reg       <= 7'h00;
			data_reg       <= 16'h0000;
			shift_reg      <= 16'h0000;
			rd_addr_reg    <= 7'h00;
			rd_active_reg  <= 1'b0;
			rd_bit_reg     <= 1'b0;
			start_seen_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				sep_pkg::SEP_IDLE: begin
					if (serial_in_in) begin
						state_reg      <= sep_pkg::SEP_OPCODE;
						cnt_reg        <= 4'h0;
						start_seen_reg <= 1'b1;
					end
				end
				sep_pkg::SEP_OPCODE: begin
					opc_reg <= {opc_reg[0], serial_in_in};
					if (cnt_reg == `SEP_OPC_LAST) begin
						state_reg <= sep_pkg::SEP_ADDRESS;
						cnt_reg   <= 4'h0;
					end else begin
						cnt_reg <= cnt_reg + 4'h1;
					end
				end
				sep_pkg::SEP_ADDRESS: begin
					addr_reg <= addr_next;
					cnt_reg  <= cnt_reg + 4'h1;
					if (addr_last) begin
						cnt_reg <= 4'h0;
						if (cmd_next == sep_pkg::SEP_CMD_READ) begin
							state_reg     <= sep_pkg::SEP_READOUT;
							rd_active_reg <= 1'b1;
							rd_bit_reg    <= 1'b0;
							shift_reg     <= rd_word;
							rd_addr_reg   <= rd_addr;
						end else if ((cmd_next == sep_pkg::SEP_CMD_WRITE) ||
						             (cmd_next == sep_pkg::SEP_CMD_FILL_ALL)) begin
							state_reg <= sep_pkg::SEP_DATA;
						end else begin
							state_reg <= sep_pkg::SEP_DONE;
						end
					end
				end
				sep_pkg::SEP_DATA: begin
					data_reg <= data_next;
					cnt_reg  <= cnt_reg + 4'h1;
					if (data_last) begin
						state_reg <= sep_pkg::SEP_DONE;
					end
				end
				sep_pkg::SEP_READOUT: begin
					rd_bit_reg <= shift_reg[msb_idx];
					shift_reg  <= {shift_reg[14:0], 1'b0};
					cnt_reg    <= cnt_reg + 4'h1;
					if (word_last) begin
						cnt_reg     <= 4'h0;
						shift_reg   <= rd_word;
						rd_addr_reg <= addr_inc;
					end
				end
				sep_pkg::SEP_DONE: begin
					state_reg <= sep_pkg::SEP_DONE;
				end
			endcase
		end
	end

	// =========================================================================
	// Completed instructions and start bits handed to the core
	// =========================================================================
	// These hold across deselect so the core can pick them up afterwards.
	always_ff @(posedge serial_clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			req_reg       <= '0;
			req_tgl_reg   <= 1'b0;
			start_tgl_reg <= 1'b0;
		end else begin
			if ((state_reg == sep_pkg::SEP_IDLE) && serial_in_in) begin
				start_tgl_reg <= ~start_tgl_reg;
			end
			if ((state_reg == sep_pkg::SEP_ADDRESS) && addr_last &&
			    (cmd_next != sep_pkg::SEP_CMD_READ) &&
			    (cmd_next != sep_pkg::SEP_CMD_WRITE) &&
			    (cmd_next != sep_pkg::SEP_CMD_FILL_ALL)) begin
				req_reg     <= '{cmd: cmd_next, addr: addr_next, data: 16'h0000};
				req_tgl_reg <= ~req_tgl_reg;
			end else if ((state_reg == sep_pkg::SEP_DATA) && data_last) begin
				req_reg     <= '{cmd: decode_cmd(opc_reg, wide_s ? addr_reg[5:4] : addr_reg[6:5]),
				                 addr: addr_reg, data: data_next};
				req_tgl_reg <= ~req_tgl_reg;
			end
		end
	end

	// =========================================================================
	// Core-side synchronisers and edge detection
	// =========================================================================
	sep_sync #(
		.WIDTH (4)
	) u_sync (
		.clk_in  (clk_in),
		.nrst_in (nrst_in),
		.d_in    ({device_select_in, ~width_select_in, req_tgl_reg, start_tgl_reg}),
		.q_out   ({cs_s, narrow_s, req_s, start_s})
	);

	// The width strap is synchronised inverted so it reads 16-bit from reset.
	// It is treated as static by the link logic.
	assign wide_s = ~narrow_s;

	assign cs_fall    = cs_prev_reg & ~cs_s;
	assign req_edge   = req_s ^ req_prev_reg;
	assign start_edge = start_s ^ start_prev_reg;
	assign exec       = cs_fall & (pending_reg | req_edge) & ~busy & ~busy_hit_reg;
	assign prog_cmd   = (req_reg.cmd == sep_pkg::SEP_CMD_WRITE) ||
	                    (req_reg.cmd == sep_pkg::SEP_CMD_ERASE) ||
	                    (req_reg.cmd == sep_pkg::SEP_CMD_CLEAR_ALL) ||
	                    (req_reg.cmd == sep_pkg::SEP_CMD_FILL_ALL);
	assign prog_start = exec & prog_cmd & enable_reg;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cs_prev_reg    <= 1'b0;
			req_prev_reg   <= 1'b0;
			start_prev_reg <= 1'b0;
		end else begin
			cs_prev_reg    <= cs_s;
			req_prev_reg   <= req_s;
			start_prev_reg <= start_s;
		end
	end

	// A new instruction waits here until the select falls.
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pending_reg <= 1'b0;
		end else if (cs_fall) begin
			pending_reg <= 1'b0;
		end else if (req_edge) begin
			pending_reg <= 1'b1;
		end
	end

	// =========================================================================
	// Program enable latch
	// =========================================================================
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			enable_reg <= 1'b0;
		end else if (exec && (req_reg.cmd == sep_pkg::SEP_CMD_PROGRAM_ENABLE)) begin
			enable_reg <= 1'b1;
		end else if (exec && (req_reg.cmd == sep_pkg::SEP_CMD_PROGRAM_DISABLE)) begin
			enable_reg <= 1'b0;
		end
	end

	// =========================================================================
	// Ready/busy status
	// =========================================================================
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			status_show_reg <= 1'b0;
		end else if (prog_start) begin
			status_show_reg <= 1'b1;
		end else if (start_edge && !busy && !busy_hit_reg) begin
			status_show_reg <= 1'b0;
		end
	end

	// A start bit taken while busy is remembered until deselect.
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			busy_hit_reg <= 1'b0;
		end else if (start_edge && busy && cs_s) begin
			busy_hit_reg <= 1'b1;
		end else if (cs_fall) begin
			busy_hit_reg <= 1'b0;
		end
	end

	// =========================================================================
	// Memory array and program engine
	// =========================================================================
	sep_array #(
		.PROG_CYCLES (PROG_CYCLES)
	) u_array (
		.clk_in      (clk_in),
		.nrst_in     (nrst_in),
		.start_in    (prog_start),
		.job_in      (req_reg),
		.wide_in     (wide_s),
		.rd_addr_in  (rd_addr),
		.rd_data_out (rd_word),
		.busy_out    (busy)
	);

	// =========================================================================
	// Serial output pin
	// =========================================================================
	assign serial_out_oe_out = rd_active_reg |
	                           (status_show_reg & cs_s & device_select_in &
	                            ~(start_seen_reg & ~busy & ~busy_hit_reg));
	assign serial_out_out    = rd_active_reg ? rd_bit_reg : ~busy;

endmodule

// *** dv/sep_port_checker.sv ***
// Pin-level checker of the serial memory command port.
`timescale 1ns/100ps
module sep_port_checker #(
	parameter int unsigned PROG_CYCLES = 20
) (
	input wire logic clk_in,            // Core clock.
	input wire logic nrst_in,           // Reset.
	input wire logic serial_clock_in,   // Link clock.
	input wire logic device_select_in,  // Select.
	input wire logic serial_in_in,      // Data in.
	input wire logic width_select_in,   // Width strap.
	input wire logic serial_out_out,    // Data out.
	input wire logic serial_out_oe_out  // Data out enable.
);
	// ========
	// Frame tracking
	logic [5:0] cnt;
	logic [1:0] op;
	logic [6:0] busy_cnt;
	wire  [5:0] alast = width_select_in ? 6'h8 : 6'h9;
	always_ff @(posedge serial_clock_in or negedge device_select_in) begin
		if (!device_select_in) begin
			cnt <= 6'h0;
		end else if ((cnt != 6'h0 || serial_in_in) && cnt != 6'h3f) begin
			cnt <= cnt + 6'h1;
		end
	end
	always_ff @(posedge serial_clock_in) begin
		if (cnt == 6'h1 || cnt == 6'h2) begin
			op <= {op[0], serial_in_in};
		end
	end
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			busy_cnt <= 7'h0;
		end else if (device_select_in && serial_out_oe_out && !serial_out_out) begin
			busy_cnt <= busy_cnt + 7'(busy_cnt != 7'h7f);
		end else begin
			busy_cnt <= 7'h0;
		end
	end
	// ========
	// Properties
	chk_oe_needs_sel: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!device_select_in |-> !serial_out_oe_out) else $error("driven while deselected");
	chk_busy_bound: assert property (@(posedge clk_in) disable iff (!nrst_in)
		32'(busy_cnt) <= PROG_CYCLES + 32'd8) else $error("busy status too long");
	chk_dummy_wide: assert property (@(posedge serial_clock_in) disable iff (!nrst_in)
		device_select_in && width_select_in && op == 2'h2 && cnt == 6'h8
		|=> !device_select_in || (serial_out_oe_out && !serial_out_out))
		else $error("no dummy zero");
	chk_dummy_byte: assert property (@(posedge serial_clock_in) disable iff (!nrst_in)
		device_select_in && !width_select_in && op == 2'h2 && cnt == 6'h9
		|=> !device_select_in || (serial_out_oe_out && !serial_out_out))
		else $error("no dummy zero in byte mode");
	chk_read_drive: assert property (@(posedge serial_clock_in) disable iff (!nrst_in)
		device_select_in && op == 2'h2 && cnt > alast |-> serial_out_oe_out)
		else $error("read output released");
	chk_frame_quiet: assert property (@(posedge serial_clock_in) disable iff (!nrst_in)
		device_select_in && cnt != 6'h0 && !(op == 2'h2 && cnt > alast)
		|-> !(serial_out_oe_out && serial_out_out)) else $error("output high in frame");
	chk_one_release: assert property (@(posedge serial_clock_in) disable iff (!nrst_in)
		device_select_in && cnt == 6'h0 && serial_in_in && serial_out_out
		|=> !device_select_in || !serial_out_oe_out) else $error("status not released");
	chk_busy_keeps: assert property (@(posedge serial_clock_in) disable iff (!nrst_in)
		device_select_in && cnt == 6'h0 && serial_in_in && serial_out_oe_out && !serial_out_out
		|=> !device_select_in || serial_out_oe_out) else $error("busy status released");
endmodule

bind sep_port sep_port_checker #(
	.PROG_CYCLES (PROG_CYCLES)
) i_sep_port_checker (
	.clk_in            (clk_in),
	.nrst_in           (nrst_in),
	.serial_clock_in   (serial_clock_in),
	.device_select_in  (device_select_in),
	.serial_in_in      (serial_in_in),
	.width_select_in   (width_select_in),
	.serial_out_out    (serial_out_out),
	.serial_out_oe_out (serial_out_oe_out)
);

// *** dv/sep_host.sv ***
// Host model driving the three-wire serial link.
`timescale 1ns/100ps
module sep_host (
	output logic      sck_out,  // Link clock, still between frames.
	output logic      sel_out,  // Device select.
	output logic      si_out,   // Serial data to the device.
	input  wire logic so_in,    // Serial data from the device.
	input  wire logic oe_in     // High while the device drives so_in.
);
	initial begin
		sck_out = 1'b0;
		sel_out = 1'b0;
		si_out = 1'b0;
	end
	// Deselect flips the data line so a stale bit never looks valid.
	task automatic pick(input logic on);
		if (on) begin
			#(1 + $urandom % 30);
			sel_out = 1'b1;
			#60;
		end else begin
			sel_out = 1'b0;
			si_out = ~si_out;
			#300;
		end
	endtask
	task automatic shift(input logic [24:0] b, input int n, output logic [24:0] got,
		output logic drv);
		got = 25'h0;
		drv = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			si_out = b[i];
			#6 sck_out = 1'b1;
			#3 got[i] = oe_in ? so_in : ~so_in;
			drv = oe_in;
			#3 sck_out = 1'b0;
		end
	endtask
endmodule

// *** dv/sep_port_tb.sv ***
// Self-checking bench of the serial memory command port.
`timescale 1ns/100ps
module sep_port_tb;
	logic        clk_in;
	logic        nrst_in;
	logic        width_select_in;
	logic        sck, sel, si, so, oe, dv;
	logic [15:0] mem [64];
	logic [24:0] g;
	logic [5:0]  a;
	logic [15:0] d;
	int          num_errors = 0;
	int          n_tests = 0;
	sep_host i_sep_host (
		.sck_out (sck),
		.sel_out (sel),
		.si_out  (si),
		.so_in   (so),
		.oe_in   (oe)
	);
	sep_port #(
		.PROG_CYCLES (20)
	) i_sep_port (
		.clk_in            (clk_in),
		.nrst_in           (nrst_in),
		.serial_clock_in   (sck),
		.device_select_in  (sel),
		.serial_in_in      (si),
		.width_select_in   (width_select_in),
		.serial_out_out    (so),
		.serial_out_oe_out (oe)
	);
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
			num_errors++;
		end
	endtask
	task automatic chk_flag(input logic got, input logic exp);
		chk_word({15'h0, got}, {15'h0, exp});
	endtask
	task automatic rst(input logic w);
		nrst_in <= 1'b0;
		width_select_in <= w;
		repeat (3) @(posedge clk_in);
		nrst_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		foreach (mem[i]) mem[i] = 16'hffff;
	endtask
	task automatic cmd(input logic [24:0] b, input int n);
		i_sep_host.pick(1'b1);
		i_sep_host.shift(b, n, g, dv);
		i_sep_host.pick(1'b0);
	endtask
	task automatic ready();
		int k;
		for (k = 0; k < 80 && so !== 1'b1; k++) @(posedge clk_in);
		if (k == 80) begin
			num_errors++;
			end_sim();
		end
	endtask
	task automatic prog(input logic [24:0] b, input int n);
		cmd(b, n);
		i_sep_host.pick(1'b1);
		#100;
		chk_flag(oe, 1'b1);
		chk_flag(so, 1'b0);
		ready();
		chk_flag(oe, 1'b1);
		i_sep_host.pick(1'b0);
	endtask
	task automatic wr(input logic [5:0] ad, input logic [15:0] v);
		prog({3'b101, ad, v}, 25);
		mem[ad] = v;
	endtask
	task automatic rd(input logic [5:0] ad, input int words);
		i_sep_host.pick(1'b1);
		i_sep_host.shift({16'h0, 3'b110, ad}, 9, g, dv);
		chk_flag(dv, 1'b1);
		chk_flag(g[0], 1'b0);
		for (int k = 0; k < words; k++) begin
			i_sep_host.shift(25'h0, 16, g, dv);
			chk_word(g[15:0], mem[6'(ad + k)]);
		end
		i_sep_host.pick(1'b0);
	endtask
	initial begin
		nrst_in = 1'b0;
		width_select_in = 1'b1;
		void'($urandom(56003));
		rst(1'b1);
		a = 6'($urandom);
		d = 16'($urandom);
		rd(a, 1);
		cmd({3'b101, a, d}, 25);
		i_sep_host.pick(1'b1);
		#100;
		chk_flag(oe, 1'b0);
		i_sep_host.pick(1'b0);
		rd(a, 1);
		$display("reset state test done");
		cmd(25'h130, 11);
		wr(a, d);
		wr(a, ~d);
		rd(a, 1);
		cmd({3'b101, a, d} >> 4, 21);
		rd(a, 1);
		wr(6'h3f, d);
		rd(6'h3f, 2);
		prog({16'h0, 3'b111, a}, 9);
		mem[a] = 16'hffff;
		rd(a, 1);
		cmd({3'b101, a, d}, 25);
		mem[a] = d;
		i_sep_host.pick(1'b1);
		#100;
		i_sep_host.shift(25'h1, 1, g, dv);
		chk_flag(dv, 1'b1);
		i_sep_host.pick(1'b0);
		i_sep_host.pick(1'b1);
		#100;
		ready();
		i_sep_host.shift(25'h1, 1, g, dv);
		chk_flag(dv, 1'b0);
		i_sep_host.pick(1'b0);
		rd(a, 1);
		$display("write and status test done");
		prog(25'h120, 9);
		foreach (mem[i]) mem[i] = 16'hffff;
		rd(a, 1);
		prog({9'h110, d}, 25);
		foreach (mem[i]) mem[i] = d;
		rd(6'h3f, 2);
		cmd(25'h100, 9);
		cmd({3'b101, a, ~d}, 25);
		rd(a, 1);
		$display("bulk and protection test done");
		rst(1'b0);
		cmd(25'h260, 10);
		prog({7'h0, 3'b101, a, 1'b1, d[7:0]}, 18);
		i_sep_host.pick(1'b1);
		i_sep_host.shift({15'h0, 3'b110, a, 1'b1}, 10, g, dv);
		chk_flag(g[0], 1'b0);
		i_sep_host.shift(25'h0, 16, g, dv);
		chk_word(g[15:0], {d[7:0], 8'hff});
		i_sep_host.pick(1'b0);
		$display("byte mode test done");
		end_sim();
	end
endmodule
